// ==== rtl/ams_sequencer.sv ====
/*
 Converter mode sequencer with its two-wire bus slave front end.
 Assumes clock is the device oscillator, i2c_clk a free-running sampling clock well above the bus bit rate,
 and open-drain bus wires resolved outside from the enable.
*/
`include "ams_regs.svh"
module ams_sequencer #(
    parameter int POR_CYCLES = `AMS_POR_CYCLES               // Power-on hold, cycles
) (
    input  wire logic                 clock,                  // Oscillator clock
    input  wire logic                 sys_rst,                // Power-on reset, sync high
    input  wire logic                 i2c_clk,                // Link sampling clock
    input  wire logic                 reset_n_pin,            // Reset pin, active low
    input  wire logic                 scl_in,                 // Bus clock level
    input  wire logic                 sda_in,                 // Bus data level
    output logic                      sda_o,                  // Data drive value
    output logic                      sda_oe,                 // Data pull-down enable
    input  wire logic                 address_strap_low_pin,  // Low address strap
    input  wire logic                 address_strap_high_pin, // High address strap
    input  wire logic [23:0]          adc_sample,             // Modulator result
    output logic [23:0]               result_out,             // Output buffer
    output logic [7:0]                cfg_out,                // Configuration register
    output logic                      conv_done,              // Conversion finished
    output logic                      analog_on,              // Oscillator and analog up
    output ams_pkg::ams_seq_state_t   seq_state               // Sequencer state
);
    import ams_pkg::*;

    localparam logic [10:0] FIRST_LAST = 11'(`AMS_FIRST_DLY_CYC - 1);
    localparam logic [10:0] CONV_LAST  = `AMS_CONV_CYCLES - 11'h001;
    localparam logic [13:0] POR_LAST   = 14'(POR_CYCLES);

    // Strap decode from idle, post-START and first-fall samples
    function automatic logic [1:0] strap_code(input logic idle_v, input logic start_v, input logic fall_v);
        strap_code = fall_v ? `AMS_STRAP_VDD : (start_v ? `AMS_STRAP_SCL : (idle_v ? `AMS_STRAP_SDA : `AMS_STRAP_GND));
    endfunction : strap_code

    logic [1:0]     rpin_sync_reg;
    logic [13:0]    por_cnt_reg;
    logic           hold_reg;
    ams_cmd_t       ev_s1_reg, ev_s2_reg, ev_s3_reg, tgl_reg, tgl_next;
    logic [1:0]     mode_sync_reg;
    ams_seq_state_t state_reg, state_next;
    logic [10:0]    cnt_reg, cnt_next;
    logic           pd_reg, pd_next, done_reg;
    logic [23:0]    result_reg;

    // Reset pin through two flops; reset command is a crossing event
    always_ff @(posedge clock) begin
        if (sys_rst) rpin_sync_reg <= 2'h3;
        else         rpin_sync_reg <= {rpin_sync_reg[0], reset_n_pin};
    end

    // Power-on hold counter
    always_ff @(posedge clock) begin
        if (sys_rst)                   por_cnt_reg <= 14'h0000;
        else if (por_cnt_reg != POR_LAST) por_cnt_reg <= por_cnt_reg + 14'h0001;
    end

    wire por_busy = por_cnt_reg != POR_LAST;
    wire hold_rst = por_busy | ~rpin_sync_reg[1];

    // Registered so the link domain sees a glitch-free level
    always_ff @(posedge clock) begin
        if (sys_rst) hold_reg <= 1'b1;
        else         hold_reg <= hold_rst;
    end

    // Event toggles and mode level into the oscillator domain
    always_ff @(posedge clock) begin
        ev_s1_reg     <= tgl_reg;
        ev_s2_reg     <= ev_s1_reg;
        ev_s3_reg     <= ev_s2_reg;
        mode_sync_reg <= {mode_sync_reg[0], cfg_out[`AMS_CFG_MODE_BIT]};
    end

    wire ams_cmd_t ev  = ev_s2_reg ^ ev_s3_reg;
    wire       mode_cont = mode_sync_reg[1];
    wire       busy      = (state_reg == AMS_SEQ_DELAY) | (state_reg == AMS_SEQ_CONV);
    wire       conv_end  = (state_reg == AMS_SEQ_CONV) & ~ev.start & ~ev.cfg_wr & (cnt_reg == CONV_LAST);

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 11'h001;
        pd_next    = pd_reg | (ev.sleep & busy);
        case (state_reg)
            AMS_SEQ_HOLD: begin
                cnt_next = 11'h000;
                if (!hold_rst) state_next = AMS_SEQ_SLEEP;
            end
            AMS_SEQ_SLEEP: begin
                cnt_next = 11'h000;
                pd_next  = 1'b0;
                if (ev.start) state_next = AMS_SEQ_DELAY;
            end
            AMS_SEQ_DELAY: begin
                if (ev.start) cnt_next = 11'h000;
                else if (cnt_reg == FIRST_LAST) begin
                    state_next = AMS_SEQ_CONV;
                    cnt_next   = 11'h000;
                end
            end
            AMS_SEQ_CONV: begin
                if (ev.start | ev.cfg_wr) cnt_next = 11'h000;
                else if (conv_end) begin
                    cnt_next = 11'h000;
                    if (pd_reg | ev.sleep | ~mode_cont) begin
                        state_next = AMS_SEQ_SLEEP;
                        pd_next    = 1'b0;
                    end
                end
            end
            default: state_next = AMS_SEQ_HOLD;
        endcase
        // Any reset wins over every command
        if (hold_rst) state_next = AMS_SEQ_HOLD;
        else if (ev.reset) state_next = AMS_SEQ_SLEEP;
        if (hold_rst | ev.reset) begin
            cnt_next = 11'h000;
            pd_next  = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= AMS_SEQ_HOLD;
            cnt_reg   <= 11'h000;
            pd_reg    <= 1'b0;
            done_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            pd_reg    <= pd_next;
            done_reg  <= conv_end & ~hold_rst & ~ev.reset;
        end
    end

    // Output buffer takes every completed result
    always_ff @(posedge clock) begin
        if (sys_rst | hold_rst)                  result_reg <= 24'h000000;
        else if (conv_end & ~ev.reset)           result_reg <= adc_sample;
    end

    assign result_out = result_reg;
    assign conv_done  = done_reg;
    assign analog_on  = (state_reg == AMS_SEQ_DELAY) | (state_reg == AMS_SEQ_CONV);
    assign seq_state  = state_reg;

    // Link domain: reset level and pins through two flops
    logic [1:0]     lrst_sync_reg;
    ams_pins_t      pin_s1_reg, pin_s2_reg, pin_s3_reg;
    ams_i2c_state_t ist_reg, ist_next;
    logic [7:0]     sh_reg, sh_next, cfg_reg, cfg_next;
    logic [3:0]     bc_reg, bc_next;
    logic           rw_reg, rw_next, gc_reg, gc_next, first_reg, first_next;
    logic           wd_reg, wd_next, mack_reg, mack_next, oe_reg, oe_next;
    logic [1:0]     idle_smp_reg, start_smp_reg;
    logic [6:0]     own_addr_reg;

    always_ff @(posedge i2c_clk) begin
        lrst_sync_reg <= {lrst_sync_reg[0], hold_reg};
        pin_s1_reg    <= '{scl_in, sda_in, address_strap_high_pin, address_strap_low_pin};
        pin_s2_reg    <= pin_s1_reg;
        pin_s3_reg    <= pin_s2_reg;
    end

    wire link_rst  = lrst_sync_reg[1];
    wire scl       = pin_s2_reg.scl;
    wire sda       = pin_s2_reg.sda;
    wire scl_rise  = scl & ~pin_s3_reg.scl;
    wire scl_fall  = ~scl & pin_s3_reg.scl;
    wire bus_start = scl & pin_s3_reg.scl & pin_s3_reg.sda & ~sda;
    wire bus_stop  = scl & pin_s3_reg.scl & ~pin_s3_reg.sda & sda;
    wire byte_end  = scl_fall & (bc_reg == 4'h8);
    wire gc_hit    = (sh_reg[7:1] == `AMS_GCALL_ADDR) & ~sh_reg[0];
    wire addr_hit  = (sh_reg[7:1] == own_addr_reg) | gc_hit;
    wire cmd_rst   = gc_reg ? (first_reg & (sh_reg == `AMS_GC_RESET)) : (~wd_reg & (sh_reg[7:1] == `AMS_CMD_RESET));

    // Strap samples: idle lines high, after START, at first falling clock
    always_ff @(posedge i2c_clk) begin
        if (link_rst) begin
            idle_smp_reg  <= 2'h0;
            start_smp_reg <= 2'h0;
            own_addr_reg  <= {`AMS_ADDR_FIXED, 4'h0};
        end else begin
            if (ist_reg == AMS_I2C_IDLE && scl && sda) idle_smp_reg <= {pin_s2_reg.strap_hi, pin_s2_reg.strap_lo};
            if (bus_start) start_smp_reg <= {pin_s2_reg.strap_hi, pin_s2_reg.strap_lo};
            if (ist_reg == AMS_I2C_ADDR && scl_fall && bc_reg == 4'h0)
                own_addr_reg <= {`AMS_ADDR_FIXED,
                                 strap_code(idle_smp_reg[1], start_smp_reg[1], pin_s2_reg.strap_hi),
                                 strap_code(idle_smp_reg[0], start_smp_reg[0], pin_s2_reg.strap_lo)};
        end
    end

    // Bus slave next state; outputs change only after a falling clock, a START or a STOP
    always_comb begin
        ist_next = ist_reg;   sh_next = sh_reg;     bc_next = bc_reg;
        rw_next = rw_reg;     gc_next = gc_reg;     first_next = first_reg;
        wd_next = wd_reg;     mack_next = mack_reg; oe_next = oe_reg;
        cfg_next = cfg_reg;   tgl_next = tgl_reg;
        case (ist_reg)
            AMS_I2C_IDLE: oe_next = 1'b0;
            AMS_I2C_ADDR, AMS_I2C_RX: begin
                if (scl_rise) begin
                    sh_next = {sh_reg[6:0], sda};
                    bc_next = bc_reg + 4'h1;
                end
                if (byte_end && ist_reg == AMS_I2C_ADDR) begin
                    if (addr_hit) begin
                        ist_next = AMS_I2C_AACK;
                        oe_next = 1'b1;
                        rw_next = sh_reg[0];
                        gc_next = gc_hit;
                        first_next = 1'b1;
                        wd_next = 1'b0;
                    end else ist_next = AMS_I2C_IDLE;
                end else if (byte_end) begin
                    ist_next = AMS_I2C_RACK;
                    oe_next = 1'b1;
                    first_next = 1'b0;
                    if (cmd_rst) begin
                        tgl_next.reset = ~tgl_reg.reset;
                        cfg_next = `AMS_CFG_DEFAULT;
                        wd_next = 1'b0;
                    end else if (wd_reg) begin
                        cfg_next = sh_reg;
                        wd_next = 1'b0;
                        tgl_next.cfg_wr = ~tgl_reg.cfg_wr;
                    end else if (!gc_reg) begin
                        if (sh_reg[7:1] == `AMS_CMD_START) tgl_next.start = ~tgl_reg.start;
                        else if (sh_reg[7:1] == `AMS_CMD_SLEEP) tgl_next.sleep = ~tgl_reg.sleep;
                        else if (sh_reg[7:2] == `AMS_CMD_WREG) wd_next = 1'b1;
                    end
                end
            end
            AMS_I2C_AACK: if (scl_fall) begin
                bc_next = 4'h0;
                if (rw_reg) begin
                    ist_next = AMS_I2C_TX;
                    sh_next = cfg_reg;
                    oe_next = ~cfg_reg[7];
                end else begin
                    ist_next = AMS_I2C_RX;
                    oe_next = 1'b0;
                end
            end
            AMS_I2C_RACK: if (scl_fall) begin
                ist_next = AMS_I2C_RX;
                oe_next = 1'b0;
                bc_next = 4'h0;
            end
            AMS_I2C_TX: begin
                if (scl_rise) bc_next = bc_reg + 4'h1;
                if (byte_end) begin
                    ist_next = AMS_I2C_TACK;
                    oe_next = 1'b0;
                end else if (scl_fall) begin
                    sh_next = {sh_reg[6:0], 1'b0};
                    oe_next = ~sh_reg[6];
                end
            end
            AMS_I2C_TACK: begin
                if (scl_rise) mack_next = sda;
                if (scl_fall) begin
                    if (!mack_reg) begin
                        ist_next = AMS_I2C_TX;
                        bc_next = 4'h0;
                        sh_next = cfg_reg;
                        oe_next = ~cfg_reg[7];
                    end else ist_next = AMS_I2C_IDLE;
                end
            end
            default: ist_next = AMS_I2C_IDLE;
        endcase
        // START and STOP override any byte in flight
        if (bus_start) begin
            ist_next = AMS_I2C_ADDR;
            bc_next = 4'h0;
            oe_next = 1'b0;
        end else if (bus_stop) begin
            ist_next = AMS_I2C_IDLE;
            oe_next = 1'b0;
        end
    end

    always_ff @(posedge i2c_clk) begin
        if (link_rst) begin
            ist_reg <= AMS_I2C_IDLE;  sh_reg <= 8'h00;    bc_reg <= 4'h0;
            rw_reg <= 1'b0;           gc_reg <= 1'b0;     first_reg <= 1'b0;
            wd_reg <= 1'b0;           mack_reg <= 1'b1;   oe_reg <= 1'b0;
            cfg_reg <= `AMS_CFG_DEFAULT;
            tgl_reg <= '0;
        end else begin
            ist_reg <= ist_next;      sh_reg <= sh_next;  bc_reg <= bc_next;
            rw_reg <= rw_next;        gc_reg <= gc_next;  first_reg <= first_next;
            wd_reg <= wd_next;        mack_reg <= mack_next; oe_reg <= oe_next;
            cfg_reg <= cfg_next;      tgl_reg <= tgl_next;
        end
    end

    // Open drain: only ever pull low; no clock output exists
    assign sda_o   = 1'b0;
    assign sda_oe  = oe_reg;
    assign cfg_out = cfg_reg;

    // Cycles since the last result, saturating; two results are too far apart for a delay range
    logic [11:0]    gap_cnt_reg;
    always_ff @(posedge clock) begin
        if (sys_rst | done_reg)          gap_cnt_reg <= 12'h000;
        else if (gap_cnt_reg != 12'hFFF) gap_cnt_reg <= gap_cnt_reg + 12'h001;
    end

    a_hold_in_reset: assert property (@(posedge clock) disable iff (sys_rst)
        hold_rst |=> state_reg == AMS_SEQ_HOLD) else $error("reset did not hold sequencer");
    a_first_delay: assert property (@(posedge clock) disable iff (sys_rst || hold_rst || ev.reset)
        (state_reg == AMS_SEQ_SLEEP && ev.start) |=> (state_reg == AMS_SEQ_DELAY) [*8])
        else $error("first conversion began too early");
    a_single_sleeps: assert property (@(posedge clock) disable iff (sys_rst || hold_rst || ev.reset)
        (conv_end && !mode_cont) |=> state_reg == AMS_SEQ_SLEEP && !analog_on && conv_done)
        else $error("single mode kept running");
    a_cont_buffers: assert property (@(posedge clock) disable iff (sys_rst || hold_rst || ev.reset)
        (conv_end && mode_cont && !pd_reg && !ev.sleep) |=> state_reg == AMS_SEQ_CONV && cnt_reg == 11'h000
        && result_out == $past(adc_sample) && conv_done) else $error("continuous result or restart missing");
    a_sleep_finishes: assert property (@(posedge clock) disable iff (sys_rst || hold_rst || ev.reset)
        (ev.sleep && state_reg == AMS_SEQ_CONV && !conv_end) |=> state_reg == AMS_SEQ_CONV && pd_reg)
        else $error("power-down cut a conversion short");
    a_cfg_restart: assert property (@(posedge clock) disable iff (sys_rst || hold_rst || ev.reset)
        (state_reg == AMS_SEQ_CONV && ev.cfg_wr) |=> state_reg == AMS_SEQ_CONV && cnt_reg == 11'h000)
        else $error("configuration write did not restart");
    a_sleep_no_conv: assert property (@(posedge clock) disable iff (sys_rst)
        (state_reg == AMS_SEQ_SLEEP && !ev.start) |=> !analog_on) else $error("conversion while asleep");
    a_sda_changes_low: assert property (@(posedge i2c_clk) disable iff (link_rst)
        (oe_reg != $past(oe_reg) && !$past(bus_start) && !$past(bus_stop)) |-> !scl)
        else $error("data changed while clock high");
    a_latch_eighth: assert property (@(posedge i2c_clk) disable iff (link_rst)
        (tgl_reg != $past(tgl_reg)) |-> $past(byte_end && ist_reg == AMS_I2C_RX)) else $error("command latched early");
    a_addr_ack: assert property (@(posedge i2c_clk) disable iff (link_rst)
        (ist_reg == AMS_I2C_ADDR && byte_end && !bus_start && sh_reg[7:1] == own_addr_reg)
        |=> oe_reg && ist_reg == AMS_I2C_AACK) else $error("own address not acknowledged");
    a_gc_reset: assert property (@(posedge i2c_clk) disable iff (link_rst)
        (ist_reg == AMS_I2C_RX && byte_end && !bus_start && gc_reg && first_reg && sh_reg == `AMS_GC_RESET)
        |=> tgl_reg.reset != $past(tgl_reg.reset) && cfg_reg == `AMS_CFG_DEFAULT) else $error("general call reset lost");
    c_single_done: cover property (@(posedge clock) disable iff (sys_rst) conv_done && !mode_cont);
    c_cont_twice: cover property (@(posedge clock) disable iff (sys_rst)
        conv_done && mode_cont && gap_cnt_reg == {1'b0, CONV_LAST});
    c_cfg_restart: cover property (@(posedge clock) disable iff (sys_rst) state_reg == AMS_SEQ_CONV && ev.cfg_wr);
    c_gc_reset: cover property (@(posedge i2c_clk) disable iff (link_rst) gc_reg && cmd_rst && byte_end);
endmodule : ams_sequencer

// ==== rtl/ams_regs.svh ====
/*
 Bus addresses, command codes, field positions, reset values and timing counts of the converter control block.
 Assumes the block clock is the device oscillator, so one t_CLK is one clock period.
*/
`ifndef AMS_REGS_SVH
`define AMS_REGS_SVH
`define AMS_ADDR_FIXED     3'h4
`define AMS_GCALL_ADDR     7'h00
`define AMS_GC_RESET       8'h06
`define AMS_CMD_RESET      7'h03
`define AMS_CMD_START      7'h04
`define AMS_CMD_SLEEP      7'h01
`define AMS_CMD_WREG       6'h10
`define AMS_CFG_DEFAULT    8'h00
`define AMS_CFG_MODE_BIT   1
`define AMS_STRAP_GND      2'h0
`define AMS_STRAP_VDD      2'h1
`define AMS_STRAP_SDA      2'h2
`define AMS_STRAP_SCL      2'h3
`define AMS_PERIOD_NS      40
`define AMS_POR_US         500
`define AMS_POR_CYCLES     ((`AMS_POR_US * 1000 + `AMS_PERIOD_NS - 1) / `AMS_PERIOD_NS)
`define AMS_FIRST_DLY_X10  285
`define AMS_FIRST_DLY_CYC  ((`AMS_FIRST_DLY_X10 + 9) / 10)
`define AMS_CONV_CYCLES    11'h40C
`endif

// ==== rtl/ams_pkg.sv ====
/*
 Types of the converter control block: state encodings and signal bundles.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ams_pkg;
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        AMS_SEQ_HOLD  = 4'h1,
        AMS_SEQ_SLEEP = 4'h2,
        AMS_SEQ_DELAY = 4'h4,
        AMS_SEQ_CONV  = 4'h8
    } ams_seq_state_t;
    // Bus slave states, one-hot
    typedef enum logic [6:0] {
        AMS_I2C_IDLE = 7'h01,
        AMS_I2C_ADDR = 7'h02,
        AMS_I2C_AACK = 7'h04,
        AMS_I2C_RX   = 7'h08,
        AMS_I2C_RACK = 7'h10,
        AMS_I2C_TX   = 7'h20,
        AMS_I2C_TACK = 7'h40
    } ams_i2c_state_t;
    // Command events, one toggle each across the domains
    typedef struct packed {
        logic start;
        logic sleep;
        logic reset;
        logic cfg_wr;
    } ams_cmd_t;
    // Pins sampled in the link domain
    typedef struct packed {
        logic scl;
        logic sda;
        logic strap_hi;
        logic strap_lo;
    } ams_pins_t;
endpackage : ams_pkg

// ==== verif/ams_i2c_master.sv ====
/*
 Two-wire bus master model that only pulls the lines low.
 Assumes the bench resolves both wires with pull-ups and feeds the data level back.
*/
module ams_i2c_master (
    input  wire logic i2c_clk,  // Link clock
    input  wire logic sda_wire, // Resolved data level
    output logic      scl_pull, // Pulls clock low
    output logic      sda_pull  // Pulls data low
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle with both lines released, so the clock rests high
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    task tk(input int n);
        repeat (n) @(posedge i2c_clk);
        #1;
    endtask : tk
    // One bit: data moves only in the clock low phase
    task bit_io(input logic b, output logic r);
        tk(4);
        sda_pull = !b;
        tk(6);
        scl_pull = 1'b0;
        tk(5);
        r = sda_wire;
        tk(5);
        scl_pull = 1'b1;
    endtask : bit_io
    task start();
        sda_pull = 1'b0;
        scl_pull = 1'b0;
        tk(10);
        sda_pull = 1'b1;
        tk(10);
        scl_pull = 1'b1;
    endtask : start
    task stop();
        tk(4);
        sda_pull = 1'b1;
        tk(6);
        scl_pull = 1'b0;
        tk(10);
        sda_pull = 1'b0;
        tk(10);
    endtask : stop
    task wr(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], a);
        bit_io(1'b1, a);
        ack = !a;
    endtask : wr
    task rd(input logic last, output logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, a);
    endtask : rd
endmodule : ams_i2c_master

// ==== verif/test_adc_mode_sequencer_i2c_slave.sv ====
/*
 Self-checking bench of the converter sequencer and its bus slave.
 Assumes straps tied low-pin to supply, high-pin to ground: slave address 41h.
*/
module test_adc_mode_sequencer_i2c_slave;
    timeunit 1ns;
    timeprecision 1ps;
    import ams_pkg::*;
    logic clock = 0, i2c_clk = 0, sys_rst = 1, reset_n_pin = 1, sda_o, sda_oe, conv_done, analog_on;
    logic scl_pull, sda_pull;
    logic [23:0] adc_sample = 24'hA5C3E1, result_out;
    logic [7:0] cfg_out, rb;
    ams_seq_state_t seq_state;
    int fails = 0, cmp_count = 0, cyc = 0, n;
    wire scl_w = !scl_pull;              // Pull-up wired-AND
    wire sda_w = !(sda_oe | sda_pull);
    logic [1:0] lo_tie = 2'h1;           // Low strap: 0 ground, 1 supply, 2 data wire, 3 clock wire
    wire strap_lo_w = (lo_tie == 2'h3) ? scl_w : ((lo_tie == 2'h2) ? sda_w : lo_tie[0]);
    initial forever #20 clock = ~clock;
    initial forever #6 i2c_clk = ~i2c_clk;
    ams_sequencer #(.POR_CYCLES(20)) i_ams_sequencer (.clock(clock), .sys_rst(sys_rst), .i2c_clk(i2c_clk),
        .reset_n_pin(reset_n_pin), .scl_in(scl_w), .sda_in(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .address_strap_low_pin(strap_lo_w), .address_strap_high_pin(1'b0), .adc_sample(adc_sample),
        .result_out(result_out), .cfg_out(cfg_out), .conv_done(conv_done), .analog_on(analog_on),
        .seq_state(seq_state));
    ams_i2c_master i_ams_i2c_master (.i2c_clk(i2c_clk), .sda_wire(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull));
    task final_report();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    // Hang guard, well above the few thousand cycles needed
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            final_report();
        end
    end
    task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task tick();
        @(posedge clock);
        #1;
    endtask : tick
    task wait_st(input ams_seq_state_t s);
        for (n = 0; seq_state !== s && n < 3000; n++) tick();
        if (n == 3000) begin
            fails++;
            $display("ERROR wait state expected %h seen %h", s, seq_state);
        end
    endtask : wait_st
    // Leading tick so a pulse already seen is not counted twice
    task wait_done();
        tick();
        for (n = 0; conv_done !== 1'b1 && n < 3000; n++) tick();
        if (n == 3000) begin
            fails++;
            $display("ERROR conv done expected 1 seen %h", conv_done);
        end
    endtask : wait_done
    task xfer(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1, input int cnt, input logic exp);
        logic ack;
        i_ams_i2c_master.start();
        i_ams_i2c_master.wr(a, ack);
        chk("addr ack", exp, ack);
        if (cnt > 0) i_ams_i2c_master.wr(b0, ack);
        if (cnt > 1) i_ams_i2c_master.wr(b1, ack);
        i_ams_i2c_master.stop();
    endtask : xfer
    task test_single();
        fork
            xfer(8'h82, 8'h08, 8'h00, 1, 1'b1);
            begin
                wait_st(AMS_SEQ_DELAY);
                for (n = 0; seq_state !== AMS_SEQ_CONV && n < 100; n++) tick();
            end
        join
        chk("start delay", 24'd29, 24'(n));
        chk("analog up", 1'b1, analog_on);
        // Configuration write mid-conversion: a fresh full conversion must follow it
        xfer(8'h82, 8'h40, 8'h00, 2, 1'b1);
        wait_done();
        chk("cfg restart", 1'b1, 24'(n > 1000));
        chk("result", 24'hA5C3E1, result_out);
        chk("back asleep", AMS_SEQ_SLEEP, seq_state);
        xfer(8'h84, 8'h08, 8'h00, 1, 1'b0);
        lo_tie = 2'h2;
        xfer(8'h84, 8'h00, 8'h00, 0, 1'b1);
        lo_tie = 2'h3;
        xfer(8'h86, 8'h00, 8'h00, 0, 1'b1);
        lo_tie = 2'h1;
        $display("test single done");
    endtask : test_single
    task test_cont();
        xfer(8'h82, 8'h40, 8'h02, 2, 1'b1);
        chk("cfg write", 8'h02, cfg_out);
        i_ams_i2c_master.start();
        i_ams_i2c_master.wr(8'h83, rb[0]);
        i_ams_i2c_master.rd(1'b1, rb);
        i_ams_i2c_master.stop();
        chk("cfg read", 8'h02, rb);
        xfer(8'h82, 8'h08, 8'h00, 1, 1'b1);
        wait_done();
        adc_sample = 24'h3C5A96;
        wait_done();
        chk("cont result", 24'h3C5A96, result_out);
        chk("cont state", AMS_SEQ_CONV, seq_state);
        xfer(8'h82, 8'h02, 8'h00, 1, 1'b1);
        chk("finish first", AMS_SEQ_CONV, seq_state);
        wait_done();
        chk("sleep", AMS_SEQ_SLEEP, seq_state);
        chk("cfg kept", 8'h02, cfg_out);
        $display("test continuous done");
    endtask : test_cont
    task test_reset();
        xfer(8'h82, 8'h06, 8'h00, 1, 1'b1);
        chk("cmd reset", 8'h00, cfg_out);
        xfer(8'h82, 8'h40, 8'h02, 2, 1'b1);
        xfer(8'h00, 8'h06, 8'h00, 1, 1'b1);
        chk("gcall reset", 8'h00, cfg_out);
        xfer(8'h82, 8'h40, 8'h02, 2, 1'b1);
        chk("sda drive", 1'b0, sda_o);
        reset_n_pin = 1'b0;
        repeat (4) tick();
        chk("pin hold", AMS_SEQ_HOLD, seq_state);
        reset_n_pin = 1'b1;
        wait_st(AMS_SEQ_SLEEP);
        chk("pin cfg", 8'h00, cfg_out);
        $display("test reset done");
    endtask : test_reset
    initial begin
        repeat (12) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        repeat (5) tick();
        chk("por hold", AMS_SEQ_HOLD, seq_state);
        wait_st(AMS_SEQ_SLEEP);
        chk("por cfg", 8'h00, cfg_out);
        repeat (10) tick();
        test_single();
        test_cont();
        test_reset();
        final_report();
    end
endmodule : test_adc_mode_sequencer_i2c_slave
